/* File: flec_pkg.sv */
// Constants shared by the flash lock-bit write and page/subsector erase logic
//
// Overview of operation
// RULE1 - Protection-bit write takes effect only when the write-arm latch is already set.
// RULE2 - Host sends opcode, three address bytes in the sector, then one data byte.
// RULE3 - Select must rise right after the data byte's eighth bit, else write dropped.
// RULE4 - Protection bits update at once; write-arm latch clears well inside deselect time.
// RULE5 - While any cycle runs, these three commands are refused and the cycle continues.
// RULE6 - Host data byte holds zeros in b7-b2, freeze in b1, guard in b0.
// RULE7 - Page erase sets the page to all ones; needs the write-arm latch set.
// RULE8 - Page erase is opcode plus three address bytes; any page address selects it.
// RULE9 - Select rising right after the last address bit starts the page erase.
// RULE10 - Busy reads one during an erase, zero after; latch cleared before completion.
// RULE11 - A page erase inside a hardware-protected area is not executed.
// RULE12 - Subsector erase sets the subsector to all ones; needs the write-arm latch set.
// RULE13 - Subsector erase is opcode plus three address bytes; any inside address selects it.
// RULE14 - Select rising right after the last address bit starts the subsector erase.
// RULE15 - Subsector erase refused if any page inside is hardware or software protected.
// RULE16 - Reset pin low aborts a running subsector erase and enters reset mode.
// RULE17 - Host waits the reset recovery time before selecting the device again.
// RULE18 - Address bits above the array size are ignored.
// RULE19 - Protection-bit write and subsector erase decode only in one process revision.
// RULE20 - Host keeps select low from the first opcode bit to the last bit.
// RULE21 - A set freeze bit blocks changes to that sector's bits until reset.
// RULE22 - A set guard bit blocks write, program and erase inside that sector.
// RULE23 - Command opcodes are settable values taken from the full instruction table.
`default_nettype none
package flec_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int PAGE_CLEAR_US = 10000;
   localparam int SUBSECT_CLEAR_US = 50000;
   localparam int DESELECT_MIN_NS = 200;
   localparam int PAGE_CLEAR_CYC = PAGE_CLEAR_US * 1000 / CLK_PERIOD_NS;
   localparam int SUBSECT_CLEAR_CYC = SUBSECT_CLEAR_US * 1000 / CLK_PERIOD_NS;
   localparam int DESELECT_CYC_RAW = DESELECT_MIN_NS / CLK_PERIOD_NS;
   localparam int DESELECT_CYC = (DESELECT_CYC_RAW < 1) ? 1 : DESELECT_CYC_RAW;
   localparam int PAGE_BITS = 8;
   localparam int SUBSECT_BITS = 12;
   localparam int SECTOR_BITS = 16;
   localparam logic [5:0] CNT_OPCODE = 6'h08;
   localparam logic [5:0] CNT_ERASE = 6'h20;
   localparam logic [5:0] CNT_LOCKW = 6'h28;
   localparam logic [5:0] CNT_MAX = 6'h3F;
   localparam logic [7:0] LOCK_RESET = 8'h00;
   localparam int LOCK_FREEZE_BIT = 1;
   localparam int LOCK_GUARD_BIT = 0;
   localparam int TIMER_W = 24;
endpackage
`default_nettype wire

/* File: flec_sync.sv */
// Two-stage synchroniser for pins entering the mclk domain
`default_nettype none
module flec_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk,        // System clock
   input wire logic resetn,      // Async reset, active low
   input wire logic [W-1:0] d,   // Asynchronous inputs
   output logic [W-1:0] q        // Synchronised outputs
);
   logic [W-1:0] meta;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: flec_timer.sv */
// Self-timed cycle down-counter with abort
`default_nettype none
module flec_timer #(
   parameter int CW = 24
) (
   input wire logic mclk,          // System clock
   input wire logic resetn,        // Async reset, active low
   input wire logic start,         // Load length and run
   input wire logic [CW-1:0] len,  // Cycle length in clocks
   input wire logic abort,         // Stop at once
   output logic busy,              // Cycle running
   output logic done               // Pulse on normal completion
);
   logic [CW-1:0] cnt;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt <= '0;
      end else if (abort) begin
         cnt <= '0;
      end else if (start) begin
         cnt <= len;
      end else if (cnt != '0) begin
         cnt <= cnt - CW'(1);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         done <= 1'b0;
      end else begin
         done <= (cnt == CW'(1)) && !abort && !start;
      end
   end

   assign busy = (cnt != '0);
endmodule
`default_nettype wire

/* File: flec_core.sv */
// Serial command decoder for protection-bit write, page erase and subsector erase
`default_nettype none
module flec_core #(
   parameter int ADDR_BITS = 18,
   parameter bit NEW_PROC = 1'b1,
   parameter logic [7:0] OP_UNLOCK = 8'h06,
   parameter logic [7:0] OP_LOCKW = 8'hE5,
   parameter logic [7:0] OP_PAGE = 8'hDB,
   parameter logic [7:0] OP_SUBSECT = 8'h20,
   parameter int PAGE_CYCLES = flec_pkg::PAGE_CLEAR_CYC,
   parameter int SUBSECT_CYCLES = flec_pkg::SUBSECT_CLEAR_CYC
) (
   input wire logic mclk,                     // System clock, 10 MHz
   input wire logic resetn,                   // Async reset, active low
   input wire logic sel_n,                    // Pin: chip select, active low
   input wire logic sclk,                     // Pin: serial clock
   input wire logic sdi,                      // Pin: serial data in
   input wire logic rst_pin_n,                // Pin: device reset, active low
   input wire logic hw_guard,                 // Pin: hardware-protect top sector
   input wire logic other_busy,               // Program/write cycle elsewhere
   input wire logic [ADDR_BITS-17:0] lock_rd_sector, // Sector to read bits of
   output logic [7:0] lock_rd_data,           // Protection bits of that sector
   output logic busy_flag,                    // Any cycle in progress
   output logic write_arm_latch,              // Write-arm latch state
   output logic erase_start,                  // Pulse: erase launched
   output logic erase_kind,                   // 0 page, 1 subsector
   output logic [ADDR_BITS-1:0] erase_base,   // Aligned base of erased area
   output logic erase_done,                   // Pulse: erase finished
   output logic erase_abort                   // Pulse: erase cut by reset pin
);
   import flec_pkg::*;

   localparam int SW = ADDR_BITS - SECTOR_BITS;
   localparam int SN = 1 << SW;
   localparam logic [ADDR_BITS-1:0] PG_MASK = ADDR_BITS'((1 << PAGE_BITS) - 1);
   localparam logic [ADDR_BITS-1:0] SS_MASK = ADDR_BITS'((1 << SUBSECT_BITS) - 1);
   localparam int A_DESEL = DESELECT_CYC;

   logic s_sel_n;
   logic s_sclk;
   logic s_sdi;
   logic s_rst_n;
   logic s_guard;
   logic sclk_q;
   logic sel_q;
   logic sclk_rise;
   logic frame_start;
   logic frame_end;
   logic [5:0] bit_cnt;
   logic [7:0] opcode;
   logic [31:0] shreg;
   logic [SN-1:0] lock_frz;
   logic [SN-1:0] lock_grd;
   logic tmr_busy;
   logic tmr_done;
   logic cmd_live;
   logic unlock_go;
   logic lock_go;
   logic pe_go;
   logic ss_go;
   logic [ADDR_BITS-1:0] er_addr;
   logic [SW-1:0] er_sect;
   logic [SW-1:0] lw_sect;
   logic [7:0] lw_data;
   logic hw_hit;
   logic er_prot;
   logic [TIMER_W-1:0] next_len;

   flec_sync #(
      .W(5),
      .INIT(5'h12)
   ) u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .d({sel_n, sclk, sdi, rst_pin_n, hw_guard}),
      .q({s_sel_n, s_sclk, s_sdi, s_rst_n, s_guard})
   );

   // Edge tracking on the synchronised pins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclk_q <= 1'b0;
         sel_q <= 1'b1;
      end else begin
         sclk_q <= s_sclk;
         sel_q <= s_sel_n;
      end
   end

   assign sclk_rise = s_sclk && !sclk_q && !s_sel_n;
   assign frame_start = !s_sel_n && sel_q;
   assign frame_end = s_sel_n && !sel_q;

   // Bit counter and shift register; reset mode ignores the bus
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt <= 6'h00;
         opcode <= 8'h00;
         shreg <= 32'h0000_0000;
      end else if (!s_rst_n || frame_start) begin
         bit_cnt <= 6'h00;
      end else if (sclk_rise) begin
         if (bit_cnt != CNT_MAX) begin
            bit_cnt <= bit_cnt + 6'h01;
         end
         shreg <= {shreg[30:0], s_sdi};
         if (bit_cnt == CNT_OPCODE - 6'h01) begin
            opcode <= {shreg[6:0], s_sdi};
         end
      end
   end

   // RULE18 upper address bits dropped
   assign er_addr = shreg[ADDR_BITS-1:0];
   assign er_sect = er_addr[SECTOR_BITS +: SW];
   assign lw_sect = shreg[8 + SECTOR_BITS +: SW];
   assign lw_data = shreg[7:0];

   // RULE11 hardware-protected top sector
   assign hw_hit = s_guard && (er_sect == SW'(SN - 1));
   // RULE15 hardware or software protection
   assign er_prot = hw_hit || lock_grd[er_sect];

   assign busy_flag = tmr_busy || other_busy;
   assign cmd_live = frame_end && s_rst_n;

   // RULE23 opcodes set by parameters
   assign unlock_go = cmd_live && (opcode == OP_UNLOCK) && (bit_cnt == CNT_OPCODE);

   // RULE1 RULE3 RULE5 RULE19 lock write acceptance
   assign lock_go = cmd_live && NEW_PROC && (opcode == OP_LOCKW) &&
                    (bit_cnt == CNT_LOCKW) && write_arm_latch && !busy_flag;

   // RULE7 RULE9 RULE22 page erase acceptance
   assign pe_go = cmd_live && (opcode == OP_PAGE) && (bit_cnt == CNT_ERASE) &&
                  write_arm_latch && !busy_flag && !er_prot;

   // RULE12 RULE14 RULE19 subsector erase acceptance
   assign ss_go = cmd_live && NEW_PROC && (opcode == OP_SUBSECT) &&
                  (bit_cnt == CNT_ERASE) && write_arm_latch && !busy_flag && !er_prot;

   // RULE4 RULE10 write-arm latch
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         write_arm_latch <= 1'b0;
      end else if (!s_rst_n || lock_go || pe_go || ss_go) begin
         write_arm_latch <= 1'b0;
      end else if (unlock_go) begin
         write_arm_latch <= 1'b1;
      end
   end

   // Volatile protection bits per sector
   for (genvar i = 0; i < SN; i++) begin : g_lock
      // RULE21 RULE4 freeze gates update
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            lock_frz[i] <= LOCK_RESET[LOCK_FREEZE_BIT];
            lock_grd[i] <= LOCK_RESET[LOCK_GUARD_BIT];
         end else if (!s_rst_n) begin
            lock_frz[i] <= LOCK_RESET[LOCK_FREEZE_BIT];
            lock_grd[i] <= LOCK_RESET[LOCK_GUARD_BIT];
         end else if (lock_go && (lw_sect == SW'(i)) && !lock_frz[i]) begin
            lock_frz[i] <= lw_data[LOCK_FREEZE_BIT];
            lock_grd[i] <= lw_data[LOCK_GUARD_BIT];
         end
      end

      // RULE21 frozen bits hold
      a_freeze_holds: assert property (@(posedge mclk) disable iff (!resetn)
         (lock_frz[i] && s_rst_n) |=> (lock_frz[i] && $stable(lock_grd[i])))
         else $error("frozen sector protection bits changed");
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         lock_rd_data <= LOCK_RESET;
      end else begin
         lock_rd_data <= {6'h00, lock_frz[lock_rd_sector], lock_grd[lock_rd_sector]};
      end
   end

   // RULE8 RULE13 launch with aligned base
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         erase_start <= 1'b0;
         erase_kind <= 1'b0;
         erase_base <= '0;
      end else begin
         erase_start <= pe_go || ss_go;
         if (pe_go) begin
            erase_kind <= 1'b0;
            erase_base <= er_addr & ~PG_MASK;
         end else if (ss_go) begin
            erase_kind <= 1'b1;
            erase_base <= er_addr & ~SS_MASK;
         end
      end
   end

   assign next_len = pe_go ? TIMER_W'(PAGE_CYCLES) : TIMER_W'(SUBSECT_CYCLES);

   flec_timer #(
      .CW(TIMER_W)
   ) u_timer (
      .mclk(mclk),
      .resetn(resetn),
      .start(pe_go || ss_go),
      .len(next_len),
      .abort(!s_rst_n),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   assign erase_done = tmr_done;

   // RULE16 abort on reset pin
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         erase_abort <= 1'b0;
      end else begin
         erase_abort <= !s_rst_n && tmr_busy;
      end
   end

   a_lock_needs_arm: assert property (@(posedge mclk) disable iff (!resetn) // RULE1
      (frame_end && !write_arm_latch && s_rst_n) |=> ($stable(lock_frz) && $stable(lock_grd)))
      else $error("protection bits changed without write-arm latch");

   a_lock_frame_len: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
      (cmd_live && (opcode == OP_LOCKW) && (bit_cnt != CNT_LOCKW))
      |=> ($stable(lock_frz) && $stable(lock_grd)))
      else $error("misframed protection write was applied");

   a_arm_clears: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
      lock_go |-> ##[1:A_DESEL] !write_arm_latch)
      else $error("write-arm latch not cleared after protection write");

   a_busy_rejects: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
      (frame_end && busy_flag) |=> (!erase_start && $stable(lock_frz)))
      else $error("command accepted while busy");

   a_page_start: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
      pe_go |=> (erase_start && !erase_kind && busy_flag && !write_arm_latch &&
                 (erase_base[PAGE_BITS-1:0] == '0)))
      else $error("page erase did not start correctly");

   a_erase_frame: assert property (@(posedge mclk) disable iff (!resetn) // RULE14
      erase_start |-> $past(bit_cnt == CNT_ERASE, 1))
      else $error("erase started from a misframed command");

   a_busy_holds: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
      (erase_start ##1 s_rst_n[*4]) |-> busy_flag)
      else $error("busy flag dropped early in erase");

   a_done_idle: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
      erase_done |-> (!tmr_busy && $past(tmr_busy, 1)))
      else $error("busy state wrong at erase completion");

   a_ss_guarded: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
      erase_start |-> (!lock_grd[erase_base[SECTOR_BITS +: SW]] &&
                       (NEW_PROC || !erase_kind) &&
                       !($past(s_guard) && (erase_base[SECTOR_BITS +: SW] == SW'(SN - 1)))))
      else $error("erase launched on protected area");

   a_reset_aborts: assert property (@(posedge mclk) disable iff (!resetn) // RULE16
      (!s_rst_n && tmr_busy) |=> (erase_abort && !tmr_busy && !write_arm_latch))
      else $error("reset pin did not abort erase");

   a_start_unarmed: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
      erase_start |-> (!write_arm_latch && tmr_busy))
      else $error("erase started with latch set or timer idle");

   a_start_pulse: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
      erase_start |=> !erase_start)
      else $error("erase start pulse longer than one cycle");

   a_start_after_end: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
      erase_start |-> $past(frame_end, 1))
      else $error("erase started without select rising");

   a_done_pulse: assert property (@(posedge mclk) disable iff (!resetn) // RULE10
      erase_done |=> !erase_done)
      else $error("erase done pulse longer than one cycle");

   a_abort_pulse: assert property (@(posedge mclk) disable iff (!resetn) // RULE16
      erase_abort |=> !erase_abort)
      else $error("erase abort pulse longer than one cycle");

   a_unlock_arms: assert property (@(posedge mclk) disable iff (!resetn) // RULE1
      unlock_go |=> write_arm_latch)
      else $error("write-unlock did not set the latch");

   a_refused_keeps: assert property (@(posedge mclk) disable iff (!resetn) // RULE11
      (cmd_live && write_arm_latch && !lock_go && !pe_go && !ss_go) |=> write_arm_latch)
      else $error("refused command cleared the latch");

   a_lock_applies: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
      (lock_go && !lock_frz[lw_sect]) |=>
      ((lock_frz[$past(lw_sect)] == $past(lw_data[LOCK_FREEZE_BIT])) &&
       (lock_grd[$past(lw_sect)] == $past(lw_data[LOCK_GUARD_BIT]))))
      else $error("protection write not applied at once");

   a_ss_align: assert property (@(posedge mclk) disable iff (!resetn) // RULE13
      (erase_start && erase_kind) |-> (erase_base[SUBSECT_BITS-1:0] == '0))
      else $error("subsector base not aligned");

   a_pin_reset_clears: assert property (@(posedge mclk) disable iff (!resetn) // RULE16
      !s_rst_n |=> ((bit_cnt == 6'h00) && !write_arm_latch && (lock_frz == '0) &&
                    (lock_grd == '0)))
      else $error("reset pin did not clear command state");

   a_guard_blocks_page: assert property (@(posedge mclk) disable iff (!resetn) // RULE22
      (cmd_live && (opcode == OP_PAGE) && lock_grd[er_sect]) |=> !erase_start)
      else $error("page erase ran in a guarded sector");

   a_hw_blocks_page: assert property (@(posedge mclk) disable iff (!resetn) // RULE11
      (cmd_live && (opcode == OP_PAGE) && hw_hit) |=> !erase_start)
      else $error("page erase ran in the hardware-protected sector");
endmodule
`default_nettype wire

/* File: flec_host.sv */
// Host serial-bus controller model driving select, clock and data
`default_nettype none
module flec_host (
   input wire logic mclk, // System clock
   output logic sel_n,    // Chip select, active low
   output logic sclk,     // Serial clock, still outside frames
   output logic sdi       // Serial data, MSB first
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   task automatic frame(input logic [39:0] bits, input int n);
      int i;
      @(posedge mclk);
      sel_n <= 1'b0;
      for (i = 0; i < n; i++) begin
         sdi <= bits[39-i];
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         repeat (4) @(posedge mclk);
         sclk <= 1'b0;
      end
      sel_n <= 1'b1;
      // Released data line must not hold its last value
      sdi <= ~bits[40-n];
      repeat (8) @(posedge mclk);
      @(negedge mclk);
   endtask
endmodule
`default_nettype wire

/* File: flash_lock_and_erase_cmds_bench.sv */
// Self-checking bench for the lock-bit write and erase decoder
`default_nettype none
module flash_lock_and_erase_cmds_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PC = 600;
   localparam int SC = 800;
   localparam logic [7:0] OP_UNLOCK = 8'h06;
   localparam logic [7:0] OP_LOCKW = 8'hE5;
   localparam logic [7:0] OP_PAGE = 8'hDB;
   localparam logic [7:0] OP_SUBSECT = 8'h20;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic rst_pin_n = 1'b1;
   logic hw_guard = 1'b0;
   logic other_busy = 1'b0;
   logic [1:0] rd_sec = 2'h0;
   wire logic sel_n, sclk, sdi;
   logic [7:0] lock_rd_data;
   logic busy_flag, write_arm_latch, erase_start, erase_kind, erase_done, erase_abort;
   logic [17:0] erase_base;
   logic kind_seen;
   logic [17:0] base_seen;
   logic [7:0] old_rd;
   logic old_start, old_kind;
   int n_done = 0;
   int n_old_ss = 0;
   int n_start = 0;
   int n_abort = 0;
   int bad_count = 0;
   int n_checks = 0;

   always #50 mclk = ~mclk;

   flec_host u_host (.mclk(mclk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi));

   flec_core #(.OP_UNLOCK(OP_UNLOCK), .OP_LOCKW(OP_LOCKW), .OP_PAGE(OP_PAGE),
      .OP_SUBSECT(OP_SUBSECT), .PAGE_CYCLES(PC), .SUBSECT_CYCLES(SC)) u_dut (
      .mclk(mclk), .resetn(resetn), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
      .rst_pin_n(rst_pin_n), .hw_guard(hw_guard), .other_busy(other_busy),
      .lock_rd_sector(rd_sec), .lock_rd_data(lock_rd_data), .busy_flag(busy_flag),
      .write_arm_latch(write_arm_latch), .erase_start(erase_start),
      .erase_kind(erase_kind), .erase_base(erase_base), .erase_done(erase_done),
      .erase_abort(erase_abort));

   // Older process revision: no protection write, no subsector erase
   flec_core #(.NEW_PROC(1'b0), .OP_UNLOCK(OP_UNLOCK), .OP_LOCKW(OP_LOCKW), .OP_PAGE(OP_PAGE),
      .OP_SUBSECT(OP_SUBSECT), .PAGE_CYCLES(PC), .SUBSECT_CYCLES(SC)) u_old (
      .mclk(mclk), .resetn(resetn), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
      .rst_pin_n(rst_pin_n), .hw_guard(hw_guard), .other_busy(other_busy),
      .lock_rd_sector(rd_sec), .lock_rd_data(old_rd), .busy_flag(),
      .write_arm_latch(), .erase_start(old_start), .erase_kind(old_kind), .erase_base(),
      .erase_done(), .erase_abort());

   // Pulses are caught in the cycle they stand
   always @(posedge mclk) begin
      if (erase_start === 1'b1) begin
         n_start++;
         kind_seen = erase_kind;
         base_seen = erase_base;
      end
      if (erase_abort === 1'b1) begin
         n_abort++;
      end
      if (erase_done === 1'b1) begin
         n_done++;
      end
      if (old_start === 1'b1 && old_kind === 1'b1) begin
         n_old_ss++;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic unlock;
      u_host.frame({OP_UNLOCK, 32'h0}, 8);
   endtask

   task automatic erase(input logic [7:0] op, input logic [23:0] addr, input int n);
      u_host.frame({op, addr, 8'h00}, n);
   endtask

   task automatic lockw(input logic [23:0] addr, input logic [7:0] d, input int n);
      u_host.frame({OP_LOCKW, addr, d}, n);
   endtask

   task automatic rd(input logic [1:0] sec, input logic [7:0] exp);
      @(posedge mclk);
      rd_sec <= sec;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check("lock bits", lock_rd_data, exp);
   endtask

   task automatic wait_end(input int lim);
      int k;
      k = 0;
      while (busy_flag !== 1'b0) begin
         @(negedge mclk);
         k++;
         if (k > lim) begin
            bad_count++;
            $display("FAIL busy wait expected 0 seen 1");
            print_verdict();
         end
      end
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      bad_count++;
      $display("FAIL run length expected end seen hang");
      print_verdict();
   end

   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      repeat (5) @(negedge mclk);
      check("latch", write_arm_latch, 0);
      rd(2'h0, 8'h00);
      erase(OP_PAGE, 24'h001234, 32);
      check("start", n_start, 0);
      unlock();
      check("latch", write_arm_latch, 1);
      erase(OP_PAGE, 24'hFC1234, 33);
      check("start", n_start, 0);
      erase(OP_PAGE, 24'hFC1234, 32);
      check("start", n_start, 1);
      check("kind", kind_seen, 0);
      check("base", base_seen, 18'h01200);
      check("busy", busy_flag, 1);
      check("latch", write_arm_latch, 0);
      unlock();
      erase(OP_SUBSECT, 24'h005000, 32);
      check("start", n_start, 1);
      wait_end(PC);
      check("busy", busy_flag, 0);
      lockw(24'h01ABCD, 8'h01, 40);
      check("latch", write_arm_latch, 0);
      rd(2'h1, 8'h01);
      check("done", n_done, 1);
      check("old lock", old_rd, 8'h00);
      unlock();
      lockw(24'h01ABCD, 8'h00, 39);
      rd(2'h1, 8'h01);
      erase(OP_PAGE, 24'h010000, 32);
      check("start", n_start, 1);
      erase(OP_SUBSECT, 24'h01F000, 32);
      check("start", n_start, 1);
      lockw(24'h020000, 8'h03, 40);
      lockw(24'h000000, 8'h01, 40);
      rd(2'h0, 8'h00);
      unlock();
      lockw(24'h020000, 8'h00, 40);
      rd(2'h2, 8'h03);
      unlock();
      @(posedge mclk);
      hw_guard <= 1'b1;
      erase(OP_PAGE, 24'h03FF00, 32);
      check("start", n_start, 1);
      check("latch", write_arm_latch, 1);
      @(posedge mclk);
      hw_guard <= 1'b0;
      other_busy <= 1'b1;
      erase(OP_PAGE, 24'h000100, 32);
      check("start", n_start, 1);
      check("busy", busy_flag, 1);
      @(posedge mclk);
      other_busy <= 1'b0;
      erase(OP_SUBSECT, 24'h005ABC, 32);
      check("start", n_start, 2);
      check("kind", kind_seen, 1);
      check("base", base_seen, 18'h05000);
      @(posedge mclk);
      rst_pin_n <= 1'b0;
      repeat (10) @(negedge mclk);
      check("abort", n_abort, 1);
      check("busy", busy_flag, 0);
      @(posedge mclk);
      rst_pin_n <= 1'b1;
      repeat (20) @(posedge mclk);
      rd(2'h1, 8'h00);
      check("latch", write_arm_latch, 0);
      check("done", n_done, 1);
      check("old ss", n_old_ss, 0);
      print_verdict();
   end
endmodule
`default_nettype wire
